// file: hdl/sdlc_frame_status_fifo.sv
// design: frame status queue and receive byte counter with an apb register slave
// ****************************************************************
// Summary of operation
// - with queue enabled and non-empty, count reads come from head entry, status reads from an upper count read up to the popping status read
// - a status register read after an upper count read saw data pops one queue entry
// - empty queue: live status is read, count registers give undefined bits
// - upper count bit 6 shows queue not empty
// - all-sent, parity and end-of-frame bits always read live
// - each entry stores three residue bits, overrun and crc error
// - repeated status reads pop at most one entry per sequence
// - upper count read latches bit 6 and selects live path if empty
// - status read on empty queue never pops or disturbs pointers
// - end of frame with queue enabled writes status and count as one entry
// - only end of frame advances the write pointer
// - overflow sets the msb of the upper count register
// - overflow and queue logic clear on reset, on clearing enable or on leaving sdlc/hdlc mode
// - byte counter is 14 bits wide, frames up to 16383 bytes
// - byte counter counts only in sdlc/hdlc mode
// - byte counter clears when a flag character is received
// - the clear follows the capture of the count into the queue
// - counter increments once per byte written to the receive data fifo
// - count reflects bytes received, not bytes read out
// - queue holds 10 entries of 19 bits, apart from the data fifo
// - queue works only when enabled and in sdlc/hdlc mode, else bypass
// - queue enable clears to 0 on reset
// - pointers reset when queue disabled and on any reset
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module sdlc_frame_status_fifo #(
    parameter int DEPTH = frame_status_pkg::QUEUE_DEPTH
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // receiver side, same clock domain
    input wire logic i_sdlc_mode,
    input wire frame_status_pkg::rx_status_t i_rx_status,
    input wire logic i_rx_byte_wr,
    input wire logic i_flag_rx,
    // state
    output logic o_queue_active,
    output logic o_queue_overflow
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic [frame_status_pkg::COUNT_WIDTH-1:0] byte_cnt_q;
    frame_status_pkg::queue_entry_t mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] fill_q;
    logic overflow_q;
    logic avail_latch_q;
    logic popped_q;
    logic [31:0] prdata_q;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire logic acc = i_psel && i_penable;
    wire logic wr_acc = acc && i_pwrite;
    wire logic rd_acc = acc && !i_pwrite;
    wire logic hit_stat = i_paddr == frame_status_pkg::ADDR_RX_COND_STATUS;
    wire logic hit_low = i_paddr == frame_status_pkg::ADDR_BYTE_COUNT_LOW;
    wire logic hit_high = i_paddr == frame_status_pkg::ADDR_BYTE_COUNT_HIGH;
    wire logic hit_ctrl = i_paddr == frame_status_pkg::ADDR_EXT_STATUS_CTRL;
    wire logic hit_any = hit_stat || hit_low || hit_high || hit_ctrl;
    wire logic q_en = ctrl_q[frame_status_pkg::QUEUE_EN_BIT];
    wire logic active = q_en && i_sdlc_mode;
    wire logic not_empty = fill_q != '0;
    wire logic full = fill_q == CNT_FULL;
    wire logic [7:0] wdat = i_pwdata[7:0];
    wire logic en_drop = wr_acc && hit_ctrl && !wdat[frame_status_pkg::QUEUE_EN_BIT];
    wire logic q_clear = !active || en_drop;
    wire logic push = active && i_rx_status.eof && !full;
    wire logic ovf_set = active && i_rx_status.eof && full;
    // head is used while enabled and non-empty, after an upper read saw data,
    // and only until the status read of that sequence has popped it
    wire logic use_head = active && not_empty && avail_latch_q && !popped_q;
    wire logic pop = rd_acc && hit_stat && use_head && !popped_q;
    frame_status_pkg::queue_entry_t head;
    assign head = mem_q[rd_ptr_q];

    // ****************************************************************
    // read data mux
    // ****************************************************************
    logic [7:0] stat_rd;
    logic [7:0] low_rd;
    logic [7:0] high_rd;
    always_comb begin
        stat_rd = '0;
        stat_rd[frame_status_pkg::ALL_SENT_BIT] = i_rx_status.all_sent;
        stat_rd[frame_status_pkg::PARITY_BIT] = i_rx_status.parity_err;
        stat_rd[frame_status_pkg::EOF_BIT] = i_rx_status.eof;
        if (use_head) begin
            stat_rd[frame_status_pkg::RESIDUE_LSB +: 3] = head.residue;
            stat_rd[frame_status_pkg::OVERRUN_BIT] = head.overrun;
            stat_rd[frame_status_pkg::CRC_ERR_BIT] = head.crc_err;
        end else begin
            stat_rd[frame_status_pkg::RESIDUE_LSB +: 3] = i_rx_status.residue;
            stat_rd[frame_status_pkg::OVERRUN_BIT] = i_rx_status.overrun;
            stat_rd[frame_status_pkg::CRC_ERR_BIT] = i_rx_status.crc_err;
        end
        // undefined when empty: the head slot is shown as is
        low_rd = head.count[7:0];
        high_rd = {2'b00, head.count[13:8]};
        high_rd[frame_status_pkg::DATA_AVAIL_BIT] = active && not_empty;
        high_rd[frame_status_pkg::OVERFLOW_BIT] = overflow_q;
    end

    wire logic [7:0] rd_sel = hit_stat ? stat_rd :
                              hit_low ? low_rd :
                              hit_high ? high_rd :
                              hit_ctrl ? ctrl_q : 8'h00;

    // ****************************************************************
    // apb answer: zero wait states, error on unmapped address
    // ****************************************************************
    assign o_pready = 1'b1;
    assign o_pslverr = acc && !hit_any;
    assign o_prdata = prdata_q;
    assign o_queue_active = active;
    assign o_queue_overflow = overflow_q;

    // read data register, updated at the setup cycle so it is stable in access
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            prdata_q <= {24'h00_0000, rd_sel};
        end
    end

    // control register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= frame_status_pkg::CTRL_RESET;
        end else if (wr_acc && hit_ctrl) begin
            ctrl_q <= wdat;
        end
    end

    // ****************************************************************
    // byte counter
    // ****************************************************************
    // eof capture uses the old value, the flag clear lands afterwards
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            byte_cnt_q <= frame_status_pkg::COUNT_RESET;
        end else if (i_sdlc_mode) begin
            if (i_flag_rx) begin
                byte_cnt_q <= frame_status_pkg::COUNT_RESET;
            end else if (i_rx_byte_wr) begin
                byte_cnt_q <= byte_cnt_q + 14'h0001;
            end
        end
    end

    // ****************************************************************
    // queue storage, one array of DEPTH entries
    // ****************************************************************
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= '{residue: i_rx_status.residue,
                                 overrun: i_rx_status.overrun,
                                 crc_err: i_rx_status.crc_err,
                                 count: byte_cnt_q};
        end
    end

    // pointers and fill level
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || q_clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
            end
            fill_q <= fill_q + CNT_W'(push) - CNT_W'(pop);
        end
    end

    // overflow flag, held until the enable is dropped or sdlc/hdlc mode is left
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || q_clear) begin
            overflow_q <= 1'b0;
        end else if (ovf_set) begin
            overflow_q <= 1'b1;
        end
    end

    // read sequence state: upper read latches availability, status read ends it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || q_clear) begin
            avail_latch_q <= 1'b0;
            popped_q <= 1'b0;
        end else if (rd_acc && hit_high) begin
            avail_latch_q <= not_empty;
            popped_q <= 1'b0;
        end else if (pop) begin
            popped_q <= 1'b1;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_pop_single: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        pop |=> !pop throughout (!(rd_acc && hit_high))[*2])
        else $error("second pop without new upper read");
    chk_no_underflow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (fill_q == '0) |-> !pop)
        else $error("pop on empty queue");
    chk_avail_bit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        high_rd[6] == (active && fill_q != '0))
        else $error("data available bit wrong");
    chk_push_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (push && !pop && !q_clear) |=> fill_q == $past(fill_q) + 1'b1)
        else $error("eof did not add an entry");
    chk_pop_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (pop && !push && !q_clear) |=> fill_q == $past(fill_q) - 1'b1)
        else $error("status read did not pop");
    chk_wr_only_eof: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!i_rx_status.eof && !q_clear) |=> $stable(wr_ptr_q))
        else $error("write pointer moved without eof");
    chk_ovf_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (overflow_q && !q_clear) |=> overflow_q)
        else $error("overflow cleared without disable");
    chk_ovf_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ovf_set |=> overflow_q)
        else $error("overflow not flagged");
    chk_cnt_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_sdlc_mode && i_flag_rx) |=> byte_cnt_q == '0)
        else $error("flag did not clear byte count");
    chk_cnt_incr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_sdlc_mode && !i_flag_rx && i_rx_byte_wr) |=> byte_cnt_q == $past(byte_cnt_q) + 1'b1)
        else $error("byte write did not count");
    chk_cnt_mode: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_sdlc_mode |=> $stable(byte_cnt_q))
        else $error("counter moved outside sdlc mode");
    chk_bypass_empty: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !active |=> fill_q == '0)
        else $error("queue held data while inactive");

    // ****************************************************************
    // checks on the bus answer and the read path
    // ****************************************************************
    // slave never stretches a transfer
    chk_pready_high: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_pready)
        else $error("pready dropped");

    // error answer only in access to an unmapped address
    chk_pslverr_map: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_pslverr == (acc && !hit_any))
        else $error("pslverr wrong");

    // read word loaded at the setup edge from the selected register
    chk_prdata_load: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_psel && !i_penable && !i_pwrite) |=> o_prdata == {24'h00_0000, $past(rd_sel)})
        else $error("read data not loaded in setup");

    // upper bits of the read word stay zero
    chk_prdata_upper: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");

    // control write lands in access
    chk_ctrl_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (wr_acc && hit_ctrl) |=> ctrl_q == $past(wdat))
        else $error("control write lost");

    // control register comes out of reset disabled
    chk_ctrl_reset: assert property (@(posedge i_core_clk)
        i_sys_rst |=> ctrl_q == frame_status_pkg::CTRL_RESET)
        else $error("control not cleared by reset");

    // all-sent, parity and end-of-frame always read live
    chk_live_bits: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        stat_rd[0] == i_rx_status.all_sent && stat_rd[4] == i_rx_status.parity_err
        && stat_rd[7] == i_rx_status.eof)
        else $error("bypass status bits not live");

    // queued status bits come from the head entry
    chk_head_status: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        use_head |-> stat_rd[3:1] == head.residue && stat_rd[5] == head.overrun
        && stat_rd[6] == head.crc_err)
        else $error("status not taken from head");

    // without a head the status path is the live one
    chk_live_path: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !use_head |-> stat_rd[3:1] == i_rx_status.residue
        && stat_rd[5] == i_rx_status.overrun && stat_rd[6] == i_rx_status.crc_err)
        else $error("live status path not selected");

    // lower count register shows the head count
    chk_low_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        low_rd == head.count[7:0] && high_rd[5:0] == head.count[13:8])
        else $error("count registers not from head");

    // overflow bit in the msb of the upper count register
    chk_ovf_bit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        high_rd[7] == overflow_q)
        else $error("overflow bit not shown");

    // ****************************************************************
    // checks on the queue control
    // ****************************************************************
    // disable or mode exit empties the queue
    chk_clear_ptrs: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        q_clear |=> fill_q == '0 && wr_ptr_q == '0 && rd_ptr_q == '0)
        else $error("pointers not reset on disable");

    // disable also clears the overflow flag
    chk_clear_ovf: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        q_clear |=> !overflow_q)
        else $error("overflow kept after disable");

    // a full queue takes no new entry
    chk_full_no_push: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        full |-> !push)
        else $error("push into full queue");

    // fill level never passes the depth
    chk_fill_bound: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        fill_q <= CNT_FULL)
        else $error("fill level above depth");

    // the entry holds status and the count before the flag clear
    chk_push_store: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        push |=> mem_q[$past(wr_ptr_q)] == $past({i_rx_status.residue,
            i_rx_status.overrun, i_rx_status.crc_err, byte_cnt_q}))
        else $error("entry not stored as captured");

    // upper count read latches availability
    chk_latch_upper: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (rd_acc && hit_high && !q_clear) |=> avail_latch_q == $past(not_empty))
        else $error("availability not latched");

    // a pop blocks further pops of the sequence
    chk_pop_latch: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (pop && !q_clear) |=> popped_q)
        else $error("pop not remembered");

    // an inactive queue is never popped
    chk_no_pop_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !active |-> !pop)
        else $error("pop while queue inactive");

    // read pointer moves only on a pop
    chk_rd_ptr_pop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!pop && !q_clear) |=> $stable(rd_ptr_q))
        else $error("read pointer moved without pop");

    // the counter wraps at its 14-bit width
    chk_cnt_wrap: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_sdlc_mode && !i_flag_rx && i_rx_byte_wr && byte_cnt_q == '1) |=> byte_cnt_q == '0)
        else $error("byte counter did not wrap");
endmodule // sdlc_frame_status_fifo

`default_nettype wire

// file: hdl/frame_status_pkg.sv
// package: register offsets, field positions, sizes and carrier types for the frame status queue
package frame_status_pkg;
    // ****************************************************************
    // register map (byte addresses on the apb bus)
    // ****************************************************************
    localparam logic [7:0] ADDR_RX_COND_STATUS = 8'h04; // receive_condition_status_reg
    localparam logic [7:0] ADDR_BYTE_COUNT_LOW = 8'h18; // byte_count_low_reg
    localparam logic [7:0] ADDR_BYTE_COUNT_HIGH = 8'h1c; // byte_count_high_fifo_status_reg
    localparam logic [7:0] ADDR_EXT_STATUS_CTRL = 8'h3c; // ext_status_irq_control_reg

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int QUEUE_EN_BIT = 2;     // queue enable in the control register
    localparam int DATA_AVAIL_BIT = 6;   // data available in the upper count register
    localparam int OVERFLOW_BIT = 7;     // overflow in the upper count register
    localparam int ALL_SENT_BIT = 0;     // status bits of the condition register, live or from the head entry
    localparam int RESIDUE_LSB = 1;
    localparam int PARITY_BIT = 4;
    localparam int OVERRUN_BIT = 5;
    localparam int CRC_ERR_BIT = 6;
    localparam int EOF_BIT = 7;

    // ****************************************************************
    // sizes and reset values
    // ****************************************************************
    localparam int QUEUE_DEPTH = 10;
    localparam int COUNT_WIDTH = 14;
    localparam int ENTRY_WIDTH = 19;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 14'h0000;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    // one queue entry: 5 status bits and the byte count
    typedef struct packed {
        logic [2:0] residue;
        logic overrun;
        logic crc_err;
        logic [COUNT_WIDTH-1:0] count;
    } queue_entry_t;

    // live receiver status and events
    typedef struct packed {
        logic all_sent;
        logic parity_err;
        logic eof;
        logic [2:0] residue;
        logic overrun;
        logic crc_err;
    } rx_status_t;
endpackage

// file: testbench/host_apb_model.sv
// host model: apb master that reads frame status in the required order
`timescale 1ns/1ps
`default_nettype none

module host_apb_model (
    // clock
    input wire logic i_core_clk,
    // apb master side
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    // ****************************************************************
    // bus transfers
    // ****************************************************************
    // bus idle from time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // one transfer: setup, access held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge i_core_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= addr;
        o_pwdata <= wd;
        @(posedge i_core_clk);
        o_penable <= 1'b1;
        // pready seen high ends this wait, else only the bench timeout
        do begin
            @(posedge i_core_clk);
        end while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask

    // frame check: upper count, lower count, then the popping status read
    task automatic read_frame(output logic [7:0] hi, output logic [7:0] lo,
                              output logic [7:0] st);
        logic [31:0] d;
        logic e;
        xfer(1'b0, frame_status_pkg::ADDR_BYTE_COUNT_HIGH, 32'h0, d, e);
        hi = d[7:0];
        xfer(1'b0, frame_status_pkg::ADDR_BYTE_COUNT_LOW, 32'h0, d, e);
        lo = d[7:0];
        xfer(1'b0, frame_status_pkg::ADDR_RX_COND_STATUS, 32'h0, d, e);
        st = d[7:0];
    endtask
endmodule // host_apb_model

`default_nettype wire

// file: testbench/sdlc_frame_status_fifo_tb.sv
// testbench: frame status queue driven by a host model and a receiver stub
`timescale 1ns/1ps
`default_nettype none

module sdlc_frame_status_fifo_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, sdlc, byte_wr, flag_rx, active, ovf, e;
    logic [7:0] paddr, hi, lo, st;
    logic [31:0] pwdata, prdata, d;
    frame_status_pkg::rx_status_t rx;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    sdlc_frame_status_fifo u_sdlc_frame_status_fifo (.i_core_clk(clk), .i_sys_rst(rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sdlc_mode(sdlc), .i_rx_status(rx), .i_rx_byte_wr(byte_wr), .i_flag_rx(flag_rx),
        .o_queue_active(active), .o_queue_overflow(ovf));
    host_apb_model u_host_apb_model (.i_core_clk(clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));

    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // register write or read through the host model
    task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        u_host_apb_model.xfer(wr, a, wd, d, e);
    endtask

    // n back-to-back bytes into the receive data fifo
    task automatic bytes(input int n);
        repeat (n) begin
            @(posedge clk);
            byte_wr <= 1'b1;
        end
        @(posedge clk);
        byte_wr <= 1'b0;
    endtask

    // end of frame with closing flag on the same edge
    task automatic frame(input logic [2:0] res, input logic ovr, input logic crc);
        @(posedge clk);
        rx.eof <= 1'b1;
        rx.residue <= res;
        rx.overrun <= ovr;
        rx.crc_err <= crc;
        flag_rx <= 1'b1;
        @(posedge clk);
        rx.eof <= 1'b0;
        flag_rx <= 1'b0;
        @(posedge clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // reset state, empty queue reads live status
    task automatic t_reset();
        reg_io(1'b0, frame_status_pkg::ADDR_EXT_STATUS_CTRL, 32'h0);
        check(d, 32'h0);
        check({31'h0, active}, 32'h0);
        u_host_apb_model.read_frame(hi, lo, st);
        check({24'h0, hi & 8'hc0}, 32'h0);
        check({24'h0, st}, 32'h11);
        reg_io(1'b0, 8'h40, 32'h0);
        check({d[30:0], e}, 32'h1);
    endtask

    // two frames queued, read back in order, extra status read
    task automatic t_frames();
        reg_io(1'b1, frame_status_pkg::ADDR_EXT_STATUS_CTRL, 32'h4);
        bytes(5);
        check({31'h0, active}, 32'h1);
        frame(3'h5, 1'b1, 1'b0);
        bytes(300);
        frame(3'h3, 1'b0, 1'b1);
        rx.residue <= 3'h2;
        rx.overrun <= 1'b0;
        rx.crc_err <= 1'b1;
        u_host_apb_model.read_frame(hi, lo, st);
        check({24'h0, hi}, 32'h40);
        check({24'h0, lo}, 32'h05);
        check({24'h0, st}, 32'h3b);
        reg_io(1'b0, frame_status_pkg::ADDR_RX_COND_STATUS, 32'h0);
        check(d, 32'h55);
        u_host_apb_model.read_frame(hi, lo, st);
        check({24'h0, hi}, 32'h41);
        check({24'h0, lo}, 32'h2c);
        check({24'h0, st}, 32'h57);
        u_host_apb_model.read_frame(hi, lo, st);
        check({24'h0, hi & 8'hc0}, 32'h0);
        check({24'h0, st}, 32'h55);
    endtask

    // ten frames fit, the eleventh overflows, toggle enable to clear
    task automatic t_overflow();
        repeat (10) begin
            bytes(1);
            frame(3'h0, 1'b0, 1'b0);
        end
        check({31'h0, ovf}, 32'h0);
        frame(3'h0, 1'b0, 1'b0);
        check({31'h0, ovf}, 32'h1);
        reg_io(1'b0, frame_status_pkg::ADDR_BYTE_COUNT_HIGH, 32'h0);
        check(d & 32'hc0, 32'hc0);
        reg_io(1'b1, frame_status_pkg::ADDR_EXT_STATUS_CTRL, 32'h0);
        reg_io(1'b1, frame_status_pkg::ADDR_EXT_STATUS_CTRL, 32'h4);
        check({31'h0, ovf}, 32'h0);
        reg_io(1'b0, frame_status_pkg::ADDR_BYTE_COUNT_HIGH, 32'h0);
        check(d & 32'hc0, 32'h0);
    endtask

    // outside sdlc mode nothing counts or queues
    task automatic t_bypass();
        sdlc <= 1'b0;
        bytes(3);
        check({31'h0, active}, 32'h0);
        frame(3'h7, 1'b1, 1'b1);
        sdlc <= 1'b1;
        rx.residue <= 3'h0;
        rx.overrun <= 1'b0;
        rx.crc_err <= 1'b0;
        bytes(2);
        frame(3'h0, 1'b0, 1'b0);
        u_host_apb_model.read_frame(hi, lo, st);
        check({24'h0, hi}, 32'h40);
        check({24'h0, lo}, 32'h02);
        check({24'h0, st}, 32'h11);
    endtask

    // main sequence
    initial begin
        sdlc = 1'b1;
        byte_wr = 1'b0;
        flag_rx = 1'b0;
        rx = '0;
        rx.all_sent = 1'b1;
        rx.parity_err = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_frames();
        t_overflow();
        t_bypass();
        wrap_up();
    end
endmodule // sdlc_frame_status_fifo_tb

`default_nettype wire
